// ===== logic/uds_pkg.sv
// Constants and carrier types of the device descriptor source.
// Assumes one 25 MHz clock domain shared with the endpoint-zero control logic.
package uds_pkg;
  // ----------------------------------------------------------------
  // Descriptor image
  // ----------------------------------------------------------------
  localparam logic [7:0]  DEV_LEN       = 8'h12;
  localparam logic [7:0]  DEV_TYPE      = 8'h01;
  localparam logic [15:0] DEF_BCD_USB   = 16'h0100;
  localparam logic [7:0]  DEF_CLASS     = 8'h00;
  localparam logic [7:0]  DEF_SUB       = 8'h00;
  localparam logic [7:0]  DEF_PROTO     = 8'h00;
  localparam logic [7:0]  DEF_MPS       = 8'h08;
  localparam logic [15:0] DEF_VID       = 16'hA5A5;  // Arbitrary value
  localparam logic [15:0] DEF_PID       = 16'h5A5A;  // Arbitrary value
  localparam logic [15:0] DEF_BCD_DEV   = 16'h0100;
  localparam logic [7:0]  DEF_I_MFR     = 8'h01;
  localparam logic [7:0]  DEF_I_PROD    = 8'h02;
  localparam logic [7:0]  DEF_I_SER     = 8'h03;
  localparam logic [7:0]  DEF_NUM_CFG   = 8'h02;
  localparam logic [7:0]  CODE_VENDOR   = 8'hFF;
  localparam logic [7:0]  MPS_8         = 8'h08;
  localparam logic [7:0]  MPS_16        = 8'h10;
  localparam logic [7:0]  MPS_32        = 8'h20;
  localparam logic [7:0]  MPS_64        = 8'h40;
  // Byte offsets inside the device descriptor
  localparam logic [4:0]  OFS_LEN   = 5'h00;
  localparam logic [4:0]  OFS_TYPE  = 5'h01;
  localparam logic [4:0]  OFS_USB_L = 5'h02;
  localparam logic [4:0]  OFS_USB_H = 5'h03;
  localparam logic [4:0]  OFS_CLASS = 5'h04;
  localparam logic [4:0]  OFS_SUB   = 5'h05;
  localparam logic [4:0]  OFS_PROTO = 5'h06;
  localparam logic [4:0]  OFS_MPS   = 5'h07;
  localparam logic [4:0]  OFS_VID_L = 5'h08;
  localparam logic [4:0]  OFS_VID_H = 5'h09;
  localparam logic [4:0]  OFS_PID_L = 5'h0A;
  localparam logic [4:0]  OFS_PID_H = 5'h0B;
  localparam logic [4:0]  OFS_REL_L = 5'h0C;
  localparam logic [4:0]  OFS_REL_H = 5'h0D;
  localparam logic [4:0]  OFS_I_MFR = 5'h0E;
  localparam logic [4:0]  OFS_I_PRD = 5'h0F;
  localparam logic [4:0]  OFS_I_SER = 5'h10;
  localparam logic [4:0]  OFS_NCFG  = 5'h11;
  // Extra descriptor store: two regions of 32 bytes
  localparam int          MEM_AW    = 6;
  localparam logic        REG_REL   = 1'b0;
  localparam logic        REG_UNREL = 1'b1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    REQ_STD_DEV = 2'h0,
    REQ_CLS_VND = 2'h1,
    REQ_OTHER   = 2'h2
  } uds_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_LOAD = 2'b11,
    ST_HOLD = 2'b10
  } uds_state_t;

  typedef struct packed {
    logic [15:0] bcd_usb;
    logic [7:0]  dev_class;
    logic [7:0]  dev_sub;
    logic        sub_private;
    logic [7:0]  dev_proto;
    logic [7:0]  mps;
    logic [15:0] vid;
    logic [15:0] pid;
    logic [15:0] bcd_dev;
    logic [7:0]  i_mfr;
    logic [7:0]  i_prod;
    logic [7:0]  i_ser;
    logic [7:0]  num_cfg;
  } uds_cfg_t;

  localparam uds_cfg_t CFG_RESET = '{DEF_BCD_USB, DEF_CLASS, DEF_SUB, 1'b0, DEF_PROTO, DEF_MPS,
                                     DEF_VID, DEF_PID, DEF_BCD_DEV, DEF_I_MFR, DEF_I_PROD,
                                     DEF_I_SER, DEF_NUM_CFG};

  typedef struct packed {
    uds_kind_t   kind;
    logic [15:0] len;
  } uds_req_t;

  typedef struct packed {
    logic        region;
    logic [4:0]  addr;
    logic [7:0]  data;
  } uds_load_t;

  typedef struct packed {
    logic [7:0]  data;
    logic        eop;
    logic        last;
  } uds_tx_t;
endpackage

// ===== logic/uds_desc_mem.sv
// Byte store for extra descriptors: region 0 served after the device descriptor, region 1 alone on class and vendor requests.
// Assumes single clock; read data appear one cycle after a read enable.
`timescale 1ns/1ns
module uds_desc_mem (
  input  wire logic                       clk_i,      // System clock
  input  wire logic                       resetn_i,   // Sync reset, active low
  input  wire logic                       wr_en_i,    // Write strobe
  input  wire logic [uds_pkg::MEM_AW-1:0] wr_addr_i,  // Write address
  input  wire logic [7:0]                 wr_data_i,  // Write byte
  input  wire logic                       rd_en_i,    // Read strobe
  input  wire logic [uds_pkg::MEM_AW-1:0] rd_addr_i,  // Read address
  output logic      [7:0]                 rd_data_o   // Registered read byte
);
  logic [7:0] mem_reg [2**uds_pkg::MEM_AW];
  logic [7:0] rd_reg;

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rd_reg <= 8'h00;
    end else if (rd_en_i) begin
      rd_reg <= mem_reg[rd_addr_i];
    end
  end

  assign rd_data_o = rd_reg;
endmodule

// ===== logic/uds_desc_source.sv
// Device descriptor source: answers descriptor requests byte by byte on endpoint zero.
// Assumes the control-transfer logic shares clk_i and drives requests and loads synchronously.
`timescale 1ns/1ns
module uds_desc_source (
  input  wire logic               clk_i,        // 25 MHz clock
  input  wire logic               resetn_i,     // Sync reset, active low
  input  wire uds_pkg::uds_cfg_t  cfg_i,        // Customisable descriptor fields
  input  wire logic               req_valid_i,  // Descriptor request strobe
  input  wire uds_pkg::uds_req_t  req_i,        // Request kind and host length
  output logic                    req_ready_o,  // Idle, request or load taken
  input  wire logic               ld_valid_i,   // Extra descriptor byte write
  input  wire uds_pkg::uds_load_t ld_i,         // Region, offset and byte
  output logic                    tx_valid_o,   // Byte offered
  output uds_pkg::uds_tx_t        tx_o,         // Byte, packet end, transfer end
  input  wire logic               tx_ready_i,   // Byte accepted
  output logic                    done_o,       // Transfer finished pulse
  output logic                    stall_o,      // Request refused pulse
  output logic                    cfg_err_o     // Configuration was corrected
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic mps_ok(input logic [7:0] m);
    return (m == uds_pkg::MPS_8) || (m == uds_pkg::MPS_16) ||
           (m == uds_pkg::MPS_32) || (m == uds_pkg::MPS_64);
  endfunction

  // Single image for the whole device, whatever configuration is active
  function automatic logic [7:0] image_byte(input uds_pkg::uds_cfg_t c, input logic [4:0] i);
    case (i)
      uds_pkg::OFS_LEN:   return uds_pkg::DEV_LEN;
      uds_pkg::OFS_TYPE:  return uds_pkg::DEV_TYPE;
      uds_pkg::OFS_USB_L: return c.bcd_usb[7:0];
      uds_pkg::OFS_USB_H: return c.bcd_usb[15:8];
      uds_pkg::OFS_CLASS: return c.dev_class;
      uds_pkg::OFS_SUB:   return c.dev_sub;
      uds_pkg::OFS_PROTO: return c.dev_proto;
      uds_pkg::OFS_MPS:   return c.mps;
      uds_pkg::OFS_VID_L: return c.vid[7:0];
      uds_pkg::OFS_VID_H: return c.vid[15:8];
      uds_pkg::OFS_PID_L: return c.pid[7:0];
      uds_pkg::OFS_PID_H: return c.pid[15:8];
      uds_pkg::OFS_REL_L: return c.bcd_dev[7:0];
      uds_pkg::OFS_REL_H: return c.bcd_dev[15:8];
      uds_pkg::OFS_I_MFR: return c.i_mfr;
      uds_pkg::OFS_I_PRD: return c.i_prod;
      uds_pkg::OFS_I_SER: return c.i_ser;
      uds_pkg::OFS_NCFG:  return c.num_cfg;
      default:            return 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Configuration sanitising
  // ----------------------------------------------------------------
  uds_pkg::uds_cfg_t cfg_reg;
  uds_pkg::uds_cfg_t cfg_next;
  logic              cfg_err_next;
  logic              cfg_err_reg;

  always_comb begin
    cfg_next     = cfg_i;
    cfg_err_next = 1'b0;
    cfg_next.sub_private = 1'b0;
    // Zero class means a zero subclass; illegal combinations are corrected, not passed
    if (cfg_i.dev_class == 8'h00 && cfg_i.dev_sub != 8'h00) begin
      cfg_next.dev_sub = 8'h00;
      cfg_err_next     = 1'b1;
    end
    if (cfg_i.sub_private && cfg_i.dev_class != uds_pkg::CODE_VENDOR) begin
      cfg_next.dev_sub = 8'h00;
      cfg_err_next     = 1'b1;
    end
    if (!mps_ok(cfg_i.mps)) begin
      cfg_next.mps = uds_pkg::DEF_MPS;
      cfg_err_next = 1'b1;
    end
  end

  // One cycle of lag buys an image that never changes halfway through a byte
  // Class and protocol codes 00..FF pass unchanged
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cfg_reg     <= uds_pkg::CFG_RESET;
      cfg_err_reg <= 1'b0;
    end else begin
      cfg_reg     <= cfg_next;
      cfg_err_reg <= cfg_err_next;
    end
  end

  // ----------------------------------------------------------------
  // Extra descriptor store
  // ----------------------------------------------------------------
  uds_pkg::uds_state_t state_reg;
  logic                rdy_reg;
  logic [7:0]          rel_len_reg;
  logic [7:0]          unrel_len_reg;
  logic                mem_rd;
  logic [5:0]          mem_addr;
  logic [7:0]          mem_data;
  logic                ld_take;
  logic                mem_region_reg;
  logic [15:0]         idx_reg;
  uds_pkg::uds_kind_t  kind_reg;
  logic [15:0]         off;

  // Loads only while idle so that a transfer never sees a half-written descriptor
  assign ld_take  = ld_valid_i && rdy_reg && state_reg == uds_pkg::ST_IDLE;
  assign off      = (kind_reg == uds_pkg::REQ_STD_DEV) ? idx_reg - 16'(uds_pkg::DEV_LEN) : idx_reg;
  assign mem_rd   = state_reg == uds_pkg::ST_ADDR;
  // Related bytes come from region 0 only after the standard image
  assign mem_addr = {(kind_reg == uds_pkg::REQ_STD_DEV) ? uds_pkg::REG_REL : uds_pkg::REG_UNREL, off[4:0]};

  // Each region holds 32 bytes; a longer stored descriptor wraps onto its own start
  uds_desc_mem u_mem (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .wr_en_i   (ld_take),
    .wr_addr_i ({ld_i.region, ld_i.addr}),
    .wr_data_i (ld_i.data),
    .rd_en_i   (mem_rd),
    .rd_addr_i (mem_addr),
    .rd_data_o (mem_data)
  );

  // The first stored byte of each descriptor is its own length
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rel_len_reg   <= 8'h00;
      unrel_len_reg <= 8'h00;
    end else if (ld_take && ld_i.addr == 5'h00) begin
      if (ld_i.region == uds_pkg::REG_REL) begin
        rel_len_reg <= ld_i.data;
      end else begin
        unrel_len_reg <= ld_i.data;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mem_region_reg <= 1'b0;
    end else if (mem_rd) begin
      mem_region_reg <= mem_addr[5];
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  logic        req_take;
  logic        req_bad;
  logic [15:0] total;
  logic [15:0] cnt_reg;
  logic [15:0] req_len_reg;
  logic [7:0]  pkt_reg;
  logic        last_byte;
  logic        pkt_end;
  logic        tx_valid_reg;
  uds_pkg::uds_tx_t tx_reg;
  logic        done_reg;
  logic        stall_reg;
  logic [7:0]  src_byte;

  assign req_take = req_valid_i && rdy_reg && state_reg == uds_pkg::ST_IDLE;
  // Unrelated descriptors never answer a standard request
  assign req_bad  = (req_i.kind == uds_pkg::REQ_OTHER) ||
                    (req_i.kind == uds_pkg::REQ_CLS_VND && unrel_len_reg == 8'h00);
  assign total    = (req_i.kind == uds_pkg::REQ_STD_DEV) ?
                    16'(uds_pkg::DEV_LEN) + {8'h00, rel_len_reg} : {8'h00, unrel_len_reg};
  assign last_byte = idx_reg == cnt_reg - 16'h0001;
  assign pkt_end   = last_byte || pkt_reg == cfg_reg.mps - 8'h01;
  assign src_byte  = (kind_reg == uds_pkg::REQ_STD_DEV && idx_reg < 16'(uds_pkg::DEV_LEN)) ?
                     image_byte(cfg_reg, idx_reg[4:0]) : mem_data;

  // Three cycles a byte (address, registered read, hold): slow, but no path from memory to the output
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_reg   <= uds_pkg::ST_IDLE;
      rdy_reg     <= 1'b0;
      idx_reg     <= 16'h0000;
      cnt_reg     <= 16'h0000;
      req_len_reg <= 16'h0000;
      kind_reg    <= uds_pkg::REQ_STD_DEV;
    end else begin
      case (state_reg)
        uds_pkg::ST_IDLE: begin
          rdy_reg <= 1'b1;
          if (req_take) begin
            rdy_reg     <= 1'b0;
            idx_reg     <= 16'h0000;
            kind_reg    <= req_i.kind;
            req_len_reg <= req_i.len;
            // Shorter of host length and descriptor length
            cnt_reg     <= (req_i.len < total) ? req_i.len : total;
            if (!req_bad && req_i.len != 16'h0000 && total != 16'h0000) begin
              state_reg <= uds_pkg::ST_ADDR;
            end
          end
        end
        uds_pkg::ST_ADDR: state_reg <= uds_pkg::ST_LOAD;
        uds_pkg::ST_LOAD: state_reg <= uds_pkg::ST_HOLD;
        uds_pkg::ST_HOLD: begin
          if (tx_ready_i) begin
            idx_reg   <= idx_reg + 16'h0001;
            state_reg <= tx_reg.last ? uds_pkg::ST_IDLE : uds_pkg::ST_ADDR;
          end
        end
        default: state_reg <= uds_pkg::ST_IDLE;
      endcase
    end
  end

  // Byte presentation; held stable until the consumer takes it
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      tx_valid_reg <= 1'b0;
      tx_reg       <= '0;
    end else if (state_reg == uds_pkg::ST_LOAD) begin
      tx_valid_reg <= 1'b1;
      tx_reg.data  <= src_byte;
      tx_reg.eop   <= pkt_end;
      tx_reg.last  <= last_byte;
    end else if (state_reg == uds_pkg::ST_HOLD && tx_ready_i) begin
      tx_valid_reg <= 1'b0;
    end
  end

  // Position within the current endpoint-zero packet
  always_ff @(posedge clk_i) begin
    if (!resetn_i || req_take) begin
      pkt_reg <= 8'h00;
    end else if (state_reg == uds_pkg::ST_HOLD && tx_ready_i) begin
      pkt_reg <= tx_reg.eop ? 8'h00 : pkt_reg + 8'h01;
    end
  end

  // One-cycle pulses: whoever waits on them must look at every edge
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      done_reg  <= 1'b0;
      stall_reg <= 1'b0;
    end else begin
      stall_reg <= req_take && req_bad;
      done_reg  <= (req_take && !req_bad && (req_i.len == 16'h0000 || total == 16'h0000)) ||
                   (state_reg == uds_pkg::ST_HOLD && tx_ready_i && tx_reg.last);
    end
  end

  assign req_ready_o = rdy_reg;
  assign tx_valid_o  = tx_valid_reg;
  assign tx_o        = tx_reg;
  assign done_o      = done_reg;
  assign stall_o     = stall_reg;
  assign cfg_err_o   = cfg_err_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_first_len_byte : assert property (
    tx_valid_o && kind_reg == uds_pkg::REQ_STD_DEV && idx_reg == 16'h0000 |-> tx_o.data == 8'h12)
    else $error("Device descriptor does not open with its length");
  a_type_byte_fixed : assert property (
    tx_valid_o && kind_reg == uds_pkg::REQ_STD_DEV && idx_reg == 16'h0001 |-> tx_o.data == 8'h01)
    else $error("Device descriptor type byte is not 01");
  a_class_zero_sub : assert property (
    cfg_i.dev_class == 8'h00 |=> cfg_reg.dev_sub == 8'h00)
    else $error("Subclass not zero under class zero");
  a_private_sub : assert property (
    cfg_i.sub_private && cfg_i.dev_class != 8'hFF |=> cfg_reg.dev_sub == 8'h00 && cfg_err_o)
    else $error("Private subclass passed without vendor class");
  a_vendor_codes : assert property (
    cfg_i.dev_class == 8'hFF && cfg_i.dev_proto == 8'hFF |=> cfg_reg.dev_class == 8'hFF &&
    cfg_reg.dev_proto == 8'hFF)
    else $error("Vendor class or protocol code altered");
  a_mps_legal : assert property (
    !mps_ok(cfg_i.mps) |=> cfg_reg.mps == 8'h08 && cfg_err_o)
    else $error("Illegal packet size not replaced by 8");
  a_len_bound : assert property (
    tx_valid_o |-> idx_reg < req_len_reg && idx_reg < cnt_reg)
    else $error("Byte beyond requested or descriptor length");
  a_pkt_bound : assert property (
    tx_valid_o && pkt_reg == cfg_reg.mps - 8'h01 |-> tx_o.eop)
    else $error("Packet longer than endpoint-zero size");
  a_related_region : assert property (
    tx_valid_o && kind_reg == uds_pkg::REQ_STD_DEV && idx_reg >= 16'h0012 |-> mem_region_reg == 1'b0)
    else $error("Standard transfer read the unrelated region");
  a_bad_req_stall : assert property (
    req_take && req_bad |=> stall_o && !tx_valid_o ##1 state_reg == uds_pkg::ST_IDLE)
    else $error("Refused request not stalled");
  a_hold_stable : assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_o))
    else $error("Offered byte changed before acceptance");
  a_first_byte_soon : assert property (
    req_take && !req_bad && req_i.len != 16'h0000 |-> ##[3:3] tx_valid_o)
    else $error("First byte late");
  // Pulse widths and hand-back timing seen from the request side, then the class descriptor length byte
  a_done_pulse : assert property (
    done_o |=> !done_o)
    else $error("Transfer end pulse longer than one cycle");
  a_stall_pulse : assert property (
    stall_o |=> !stall_o)
    else $error("Refusal pulse longer than one cycle");
  a_ready_after_done : assert property (
    done_o |=> req_ready_o)
    else $error("Ready not back one cycle after transfer end");
  a_busy_not_ready : assert property (
    tx_valid_o |-> !req_ready_o)
    else $error("New request accepted during a transfer");
  a_class_len_first : assert property (
    tx_valid_o && kind_reg == uds_pkg::REQ_CLS_VND && idx_reg == 16'h0000 |-> tx_o.data == unrel_len_reg)
    else $error("Class descriptor does not open with its length");

  // Scenarios worth seeing at least once
  c_std_done : cover property (kind_reg == uds_pkg::REQ_STD_DEV && done_o);
  c_slow_hold : cover property (tx_valid_o && !tx_ready_i);
  c_cls_done : cover property (kind_reg == uds_pkg::REQ_CLS_VND && done_o);
  c_mid_eop  : cover property (tx_valid_o && tx_o.eop && !tx_o.last);
  c_stall    : cover property (stall_o);
endmodule

// ===== tb/uds_host_model.sv
// Host side of endpoint zero: takes descriptor bytes and keeps them with their markers.
// Assumes the source offers one byte at a time and holds it until taken.
`timescale 1ns/1ns
module uds_host_model (
  input  wire logic             clk_i,       // System clock
  input  wire logic             slow_i,      // Take only one cycle in four
  input  wire logic             tx_valid_i,  // Byte offered
  input  wire uds_pkg::uds_tx_t tx_i,        // Byte, packet end, transfer end
  output logic                  tx_ready_o   // Byte taken
);
  logic [7:0] got_q[$];
  logic [1:0] mark_q[$];
  logic [1:0] div_reg = 2'h0;

  initial tx_ready_o = 1'b0;

  // ----------------------------------------------------------------
  // Byte intake
  // ----------------------------------------------------------------
  // Ready moves just after the edge so the source never sees it change at the sampling point
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got_q.push_back(tx_i.data);
      mark_q.push_back({tx_i.eop, tx_i.last});
    end
    div_reg    <= div_reg + 2'h1;
    tx_ready_o <= #1 !slow_i || (div_reg == 2'h3);
  end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the device descriptor source.
// Assumes uds_host_model consumes the bytes; inputs move 1 ns after each rising edge.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  logic               clk_i = 1'b0, resetn_i = 1'b0, req_valid = 1'b0, ld_valid = 1'b0, slow = 1'b0;
  uds_pkg::uds_cfg_t  cfg = uds_pkg::CFG_RESET;
  uds_pkg::uds_req_t  req = '0;
  uds_pkg::uds_load_t ld = '0;
  uds_pkg::uds_tx_t   tx;
  logic               req_ready, tx_valid, tx_ready, done, stall, cfg_err, s_done, s_stall;
  logic [7:0]         rel[$], exp[$];
  int                 n_fail = 0, compares = 0;

  always #20 clk_i = ~clk_i;

  uds_desc_source i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .cfg_i(cfg), .req_valid_i(req_valid),
    .req_i(req), .req_ready_o(req_ready), .ld_valid_i(ld_valid), .ld_i(ld), .tx_valid_o(tx_valid),
    .tx_o(tx), .tx_ready_i(tx_ready), .done_o(done), .stall_o(stall), .cfg_err_o(cfg_err));
  uds_host_model i_host (.clk_i(clk_i), .slow_i(slow), .tx_valid_i(tx_valid), .tx_i(tx),
    .tx_ready_o(tx_ready));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask

  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wait_ready();
    int k;
    for (k = 0; k < 100 && req_ready !== 1'b1; k++) tick();
    if (k == 100) begin
      n_fail++;
      $display("mismatch req_ready expected 1 seen %b", req_ready);
      report_and_stop();
    end
  endtask

  // Leading tick keeps a strobe from being lowered and raised in one time step
  task automatic load(input logic r, input logic [4:0] a, input logic [7:0] d);
    tick();
    wait_ready();
    ld_valid = 1'b1;
    ld = '{r, a, d};
    tick();
    ld_valid = 1'b0;
  endtask

  task automatic run(input uds_pkg::uds_kind_t kind, input logic [15:0] len);
    int k;
    i_host.got_q.delete();
    i_host.mark_q.delete();
    tick();
    wait_ready();
    req_valid = 1'b1;
    req = '{kind, len};
    tick();
    req_valid = 1'b0;
    // Refusals and empty transfers answer at the take edge, so look before the next edge
    `CHK("req_ready busy", 1'b0, req_ready)
    s_done = (done === 1'b1);
    s_stall = (stall === 1'b1);
    for (k = 0; k < 500 && !(s_done || s_stall); k++) begin
      tick();
      s_done = (done === 1'b1);
      s_stall = (stall === 1'b1);
    end
    if (!(s_done || s_stall)) begin
      n_fail++;
      $display("mismatch transfer end expected 1 seen 0");
      report_and_stop();
    end
  endtask

  // Expected image in wire order, low byte of each word first
  task automatic build(input uds_pkg::uds_cfg_t e, input int len);
    exp = '{8'h12, 8'h01, e.bcd_usb[7:0], e.bcd_usb[15:8], e.dev_class, e.dev_sub, e.dev_proto, e.mps,
            e.vid[7:0], e.vid[15:8], e.pid[7:0], e.pid[15:8], e.bcd_dev[7:0], e.bcd_dev[15:8],
            e.i_mfr, e.i_prod, e.i_ser, e.num_cfg};
    exp = {exp, rel};
    while (exp.size() > len) void'(exp.pop_back());
  endtask

  task automatic check(input int mps);
    `CHK("done", 1'b1, s_done)
    `CHK("count", exp.size(), i_host.got_q.size())
    foreach (exp[i]) begin
      `CHK("byte", exp[i], i_host.got_q[i])
      `CHK("marks", {(i + 1) % mps == 0 || i == exp.size() - 1, i == exp.size() - 1}, i_host.mark_q[i])
    end
  endtask

  function automatic uds_pkg::uds_cfg_t mk(input logic [7:0] cl, sb, input logic pv, input logic [7:0] pr, mp);
    mk = '{16'h0110, cl, sb, pv, pr, mp, 16'h1234, 16'h4321, 16'h0210, 8'h04, 8'h05, 8'h06, 8'h01};
  endfunction

  task automatic cfg_case(input uds_pkg::uds_cfg_t c, e, input logic err);
    cfg = c;
    repeat (3) tick();
    `CHK("cfg_err", err, cfg_err)
    build(e, 18);
    run(uds_pkg::REQ_STD_DEV, 16'h0012);
    check(int'(e.mps));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_default();
    build(uds_pkg::CFG_RESET, 18);
    run(uds_pkg::REQ_STD_DEV, 16'h0012);
    check(8);
    `CHK("cfg_err default", 1'b0, cfg_err)
    $display("test default image done");
  endtask

  task automatic t_trunc();
    slow = 1'b1;
    build(uds_pkg::CFG_RESET, 5);
    run(uds_pkg::REQ_STD_DEV, 16'h0005);
    check(8);
    build(uds_pkg::CFG_RESET, 0);
    run(uds_pkg::REQ_STD_DEV, 16'h0000);
    check(8);
    slow = 1'b0;
    $display("test truncation done");
  endtask

  task automatic t_cfg();
    cfg_case(mk(8'hFF, 8'h33, 1'b1, 8'hFF, 8'h40), mk(8'hFF, 8'h33, 1'b1, 8'hFF, 8'h40), 1'b0);
    cfg_case(mk(8'h00, 8'h05, 1'b0, 8'h00, 8'h10), mk(8'h00, 8'h00, 1'b0, 8'h00, 8'h10), 1'b1);
    cfg_case(mk(8'h03, 8'h07, 1'b1, 8'h01, 8'h0C), mk(8'h03, 8'h00, 1'b1, 8'h01, 8'h08), 1'b1);
    cfg_case(mk(8'h02, 8'h01, 1'b0, 8'h01, 8'h20), mk(8'h02, 8'h01, 1'b0, 8'h01, 8'h20), 1'b0);
    cfg = uds_pkg::CFG_RESET;
    repeat (2) tick();
    $display("test customisation done");
  endtask

  task automatic t_class();
    logic [7:0] un[$] = '{8'h04, 8'h24, 8'h11, 8'h22};
    run(uds_pkg::REQ_OTHER, 16'h0040);
    `CHK("stall other", 1'b1, s_stall)
    `CHK("bytes other", 0, i_host.got_q.size())
    run(uds_pkg::REQ_CLS_VND, 16'h0040);
    `CHK("stall empty", 1'b1, s_stall)
    foreach (un[i]) load(1'b1, 5'(i), un[i]);
    exp = un;
    run(uds_pkg::REQ_CLS_VND, 16'h0040);
    check(8);
    build(uds_pkg::CFG_RESET, 64);
    run(uds_pkg::REQ_STD_DEV, 16'h0040);
    check(8);
    $display("test class request done");
  endtask

  task automatic t_related();
    rel = '{8'h03, 8'h21, 8'h5C};
    foreach (rel[i]) load(1'b0, 5'(i), rel[i]);
    build(uds_pkg::CFG_RESET, 64);
    run(uds_pkg::REQ_STD_DEV, 16'h0040);
    check(8);
    slow = 1'b1;
    build(uds_pkg::CFG_RESET, 20);
    run(uds_pkg::REQ_STD_DEV, 16'h0014);
    check(8);
    slow = 1'b0;
    $display("test related descriptor done");
  endtask

  initial begin
    repeat (5) tick();
    resetn_i = 1'b1;
    t_default();
    t_trunc();
    t_cfg();
    t_class();
    t_related();
    report_and_stop();
  end
endmodule
